// file: src/gcca_top.sv
// global configuration word, line clock activity bits and expansion clock
//
// Contract
// R1: eight tx activity bits at 31:28, 23:20; eight rx at 27:24, 19:16.
// R2: activity bits are read only and clear to zero after each read.
// R3: group reset, soft group reset or soft chip reset clear that group's bits.
// R4: a zero activity bit sets on the second rising edge of its line clock.
// R5: groups sharing one serial port follow that port's line clock.
// R6: without line clock edges the activity bit stays at zero.
// R7: group memory read with absent line clock returns the dead-access word.
// R8: group memory write with absent line clock is discarded.
// R9: after releasing expansion bus wait gap field plus four clocks.
// R10: expansion clock enable low leaves the expansion clock pin undriven.
// R11: expansion clock enable high drives the inverted host clock out.
// R12: global configuration is taken from the channel group 0 copy only.
// R13: host reads group 0 copy or copies it and requests init per group.
// R14: host aligns each group descriptor block to a 2 kB boundary.
// R15: line clocks are synchronised before updating the activity bits.
`timescale 1ns/100ps
`default_nettype none
`include "gcca_params.svh"
module gcca_top
  import gcca_pkg::*;
#(
  parameter int NGRP = 8,
  parameter int ABSENT_CYCLES = `GCCA_ABSENT_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_soft_chip_rst,
  input wire logic [NGRP-1:0] i_soft_grp_rst,
  input wire logic [NGRP-1:0] i_tx_line_clock,
  input wire logic [NGRP-1:0] i_rx_line_clock,
  input wire logic i_cfg_wr,
  input wire logic [2:0] i_cfg_grp,
  input wire logic [31:0] i_cfg_wdata,
  input wire logic i_cfg_rd,
  output logic [31:0] o_cfg_rdata,
  output logic o_cfg_rvalid,
  input wire gcca_mem_req_s i_mem_req,
  input wire logic [31:0] i_ram_rdata,
  output logic o_ram_we,
  output logic [31:0] o_mem_rdata,
  output logic o_mem_rvalid,
  input wire logic i_ebus_release,
  output logic o_ebus_req_ok,
  output logic o_ebus_clock_o,
  output logic o_ebus_clock_oe
);
  // ********************************************************
  // line clock synchronisers and edge detect
  // ********************************************************
  logic [NGRP-1:0] tx_s1_q, tx_s2_q, tx_s3_q;
  logic [NGRP-1:0] rx_s1_q, rx_s2_q, rx_s3_q;
  logic [NGRP-1:0] tx_port_edge, rx_port_edge;

  // line clocks run far below i_clk, so a two-stage capture is enough
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tx_s1_q <= '0;
      tx_s2_q <= '0;
      tx_s3_q <= '0;
      rx_s1_q <= '0;
      rx_s2_q <= '0;
      rx_s3_q <= '0;
    end else begin
      tx_s1_q <= i_tx_line_clock; // see R15
      tx_s2_q <= tx_s1_q;
      tx_s3_q <= tx_s2_q;
      rx_s1_q <= i_rx_line_clock;
      rx_s2_q <= rx_s1_q;
      rx_s3_q <= rx_s2_q;
    end
  end

  assign tx_port_edge = tx_s2_q & ~tx_s3_q;
  assign rx_port_edge = rx_s2_q & ~rx_s3_q;

  // ********************************************************
  // configuration word
  // ********************************************************
  logic [31:0] cfg_q, cfg_d;
  logic [1:0] pmap;

  always_comb begin
    cfg_d = cfg_q;
    if (i_soft_chip_rst) begin
      cfg_d = `GCCA_CFG_RESET;
    end else if (i_cfg_wr && i_cfg_grp == 3'h0) begin
      // other groups' copies are ignored; activity bits are not writable
      cfg_d = {16'h0000, 1'b0, i_cfg_wdata[`GCCA_GAP_MSB:0]}; // see R12
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cfg_q <= `GCCA_CFG_RESET;
    end else begin
      cfg_q <= cfg_d;
    end
  end

  assign pmap = cfg_q[`GCCA_PMAP_MSB:`GCCA_PMAP_LSB];

  // ********************************************************
  // per-group activity bits
  // ********************************************************
  logic [NGRP-1:0] tx_seen, rx_seen, tx_pres, rx_pres;
  logic [NGRP-1:0] grp_clr;
  logic rd_take;

  assign rd_take = i_cfg_rd;
  assign grp_clr = i_soft_grp_rst | {NGRP{i_soft_chip_rst}}; // see R3

  for (genvar g = 0; g < NGRP; g++) begin : g_grp
    logic [2:0] port;
    // port map 3 is reserved; treated as the default one-to-one map
    assign port = (pmap == 2'h1) ? 3'(g / 2) : (pmap == 2'h2) ? 3'(g / 4) : 3'(g); // see R5
    gcca_act_det #(.ABSENT_CYCLES(ABSENT_CYCLES)) u_tx (
      .i_clk(i_clk),
      .i_rst_n(i_rst_n),
      .i_edge(tx_port_edge[port]),
      .i_rd_clr(rd_take),
      .i_grp_clr(grp_clr[g]),
      .o_seen(tx_seen[g]),
      .o_present(tx_pres[g])
    );
    gcca_act_det #(.ABSENT_CYCLES(ABSENT_CYCLES)) u_rx (
      .i_clk(i_clk),
      .i_rst_n(i_rst_n),
      .i_edge(rx_port_edge[port]),
      .i_rd_clr(rd_take),
      .i_grp_clr(grp_clr[g]),
      .o_seen(rx_seen[g]),
      .o_present(rx_pres[g])
    );
  end

  // ********************************************************
  // configuration read
  // ********************************************************
  logic [31:0] rdata_q, rdata_d;
  logic rvalid_q;

  always_comb begin
    rdata_d = rdata_q;
    if (rd_take) begin
      rdata_d = cfg_q;
      rdata_d[`GCCA_TX_HI_LSB +: 4] = tx_seen[7:4]; // see R1
      rdata_d[`GCCA_RX_HI_LSB +: 4] = rx_seen[7:4];
      rdata_d[`GCCA_TX_LO_LSB +: 4] = tx_seen[3:0];
      rdata_d[`GCCA_RX_LO_LSB +: 4] = rx_seen[3:0];
      rdata_d[`GCCA_RESERVED_BIT] = 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rdata_q <= 32'h0000_0000;
      rvalid_q <= 1'b0;
    end else begin
      rdata_q <= rdata_d;
      rvalid_q <= rd_take;
    end
  end

  assign o_cfg_rdata = rdata_q;
  assign o_cfg_rvalid = rvalid_q;

  // ********************************************************
  // group memory gating
  // ********************************************************
  logic grp_alive;
  logic [31:0] mrd_q, mrd_d;
  logic mrv_q;

  assign grp_alive = tx_pres[i_mem_req.grp] | rx_pres[i_mem_req.grp];
  assign o_ram_we = i_mem_req.wr && grp_alive; // see R8

  always_comb begin
    mrd_d = mrd_q;
    if (i_mem_req.rd) begin
      mrd_d = grp_alive ? i_ram_rdata : `GCCA_DEAD_WORD; // see R7
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mrd_q <= 32'h0000_0000;
      mrv_q <= 1'b0;
    end else begin
      mrd_q <= mrd_d;
      mrv_q <= i_mem_req.rd;
    end
  end

  assign o_mem_rdata = mrd_q;
  assign o_mem_rvalid = mrv_q;

  // ********************************************************
  // expansion bus release gap
  // ********************************************************
  gcca_gap_e st_q, st_d;
  logic [3:0] gap_q, gap_d;

  always_comb begin
    st_d = st_q;
    gap_d = gap_q;
    unique case (st_q)
      GCCA_IDLE: begin
        if (i_ebus_release) begin
          st_d = GCCA_GAP;
          gap_d = 4'({1'b0, cfg_q[`GCCA_GAP_MSB:`GCCA_GAP_LSB]} + `GCCA_GAP_BASE - 1); // see R9
        end
      end
      GCCA_GAP: begin
        if (gap_q == 4'h0) begin
          st_d = GCCA_IDLE;
        end else begin
          gap_d = gap_q - 4'h1;
        end
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_q <= GCCA_IDLE;
      gap_q <= 4'h0;
    end else begin
      st_q <= st_d;
      gap_q <= gap_d;
    end
  end

  assign o_ebus_req_ok = (st_q == GCCA_IDLE);

  // ********************************************************
  // expansion clock output
  // ********************************************************
  // expansion clock periods equal host clock periods, hence the plain count above
  assign o_ebus_clock_o = ~i_clk; // see R11
  assign o_ebus_clock_oe = cfg_q[`GCCA_CLK_OUT_EN_BIT]; // see R10

  AST_DEAD_READ: assert property (@(posedge i_clk) disable iff (!i_rst_n) // see R7
    i_mem_req.rd && !grp_alive |=> o_mem_rvalid && o_mem_rdata == `GCCA_DEAD_WORD)
    else $error("absent clock read did not return dead word");
  AST_WRITE_DROP: assert property (@(posedge i_clk) disable iff (!i_rst_n) // see R8
    i_mem_req.wr && !(tx_pres[i_mem_req.grp] || rx_pres[i_mem_req.grp]) |-> !o_ram_we)
    else $error("absent clock write reached memory");
  AST_GAP_MIN: assert property (@(posedge i_clk) disable iff (!i_rst_n) // see R9
    o_ebus_req_ok && i_ebus_release |=> !o_ebus_req_ok [*4])
    else $error("expansion bus gap shorter than four clocks");
  AST_GAP_MAX: assert property (@(posedge i_clk) disable iff (!i_rst_n) // see R9
    o_ebus_req_ok && i_ebus_release |-> ##[5:12] o_ebus_req_ok)
    else $error("expansion bus gap longer than eleven clocks");
  AST_CLK_OUT_EN: assert property (@(posedge i_clk) disable iff (!i_rst_n) // see R10
    i_cfg_wr && i_cfg_grp == 3'h0 && !i_soft_chip_rst
    |=> o_ebus_clock_oe == $past(i_cfg_wdata[`GCCA_CLK_OUT_EN_BIT]))
    else $error("expansion clock enable does not follow configuration");
  AST_GRP0_ONLY: assert property (@(posedge i_clk) disable iff (!i_rst_n) // see R12
    i_cfg_wr && i_cfg_grp != 3'h0 && !i_soft_chip_rst |=> $stable(o_ebus_clock_oe))
    else $error("non-zero group copy changed configuration");
  AST_RESERVED_ZERO: assert property (@(posedge i_clk) disable iff (!i_rst_n) // see R1
    o_cfg_rvalid |-> !o_cfg_rdata[`GCCA_RESERVED_BIT])
    else $error("reserved bit read as one");
endmodule
`default_nettype wire

// file: src/gcca_params.svh
// constants for the global configuration and clock activity block
`ifndef GCCA_PARAMS_SVH
`define GCCA_PARAMS_SVH

`define GCCA_TX_HI_LSB 28
`define GCCA_RX_HI_LSB 24
`define GCCA_TX_LO_LSB 20
`define GCCA_RX_LO_LSB 16
`define GCCA_RESERVED_BIT 15
`define GCCA_GAP_MSB 14
`define GCCA_GAP_LSB 12
`define GCCA_CLK_OUT_EN_BIT 11
`define GCCA_PMAP_MSB 1
`define GCCA_PMAP_LSB 0
`define GCCA_CFG_RESET 32'h0000_0000
`define GCCA_DEAD_WORD 32'hDEAD_ACCE
`define GCCA_GAP_BASE 4
`define GCCA_CLK_PERIOD_NS 4
`define GCCA_ABSENT_NS 2000
`define GCCA_ABSENT_CYCLES (`GCCA_ABSENT_NS / `GCCA_CLK_PERIOD_NS)

`endif

// file: src/gcca_pkg.sv
// types for the global configuration and clock activity block
package gcca_pkg;
  typedef struct packed {
    logic rd;
    logic wr;
    logic [2:0] grp;
  } gcca_mem_req_s;

  typedef enum logic [0:0] {
    GCCA_IDLE,
    GCCA_GAP
  } gcca_gap_e;
endpackage

// file: src/gcca_act_det.sv
// per-group, per-direction line clock activity bit and presence detector
`timescale 1ns/100ps
`default_nettype none
`include "gcca_params.svh"
module gcca_act_det #(
  parameter int ABSENT_CYCLES = `GCCA_ABSENT_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_edge,
  input wire logic i_rd_clr,
  input wire logic i_grp_clr,
  output logic o_seen,
  output logic o_present
);
  localparam int CW = $clog2(ABSENT_CYCLES + 1);
  localparam logic [CW-1:0] ABS_MAX = CW'(ABSENT_CYCLES);

  logic seen_q, seen_d;
  logic first_q, first_d;
  logic [CW-1:0] idle_q, idle_d;
  logic set;

  always_comb begin
    set = i_edge && !seen_q && first_q; // see R4
    seen_d = seen_q;
    first_d = first_q;
    if (i_edge && !seen_q) begin
      first_d = 1'b1;
    end
    if (set) begin
      seen_d = 1'b1;
    end else if (i_rd_clr) begin
      // edge coinciding with the read counts as the new first edge
      seen_d = 1'b0; // see R2
      first_d = i_edge;
    end
    if (i_grp_clr) begin
      seen_d = 1'b0; // see R3
      first_d = 1'b0;
    end
    if (i_edge) begin
      idle_d = '0;
    end else if (idle_q != ABS_MAX) begin
      idle_d = idle_q + CW'(1);
    end else begin
      idle_d = idle_q;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      seen_q <= 1'b0;
      first_q <= 1'b0;
      idle_q <= ABS_MAX;
    end else begin
      seen_q <= seen_d;
      first_q <= first_d;
      idle_q <= idle_d;
    end
  end

  assign o_seen = seen_q;
  assign o_present = (idle_q != ABS_MAX);

  AST_READ_CLEARS: assert property (@(posedge i_clk) disable iff (!i_rst_n) // see R2
    i_rd_clr && !(i_edge && first_q) |=> !o_seen)
    else $error("activity bit not cleared by read");
  AST_GROUP_CLEARS: assert property (@(posedge i_clk) disable iff (!i_rst_n) // see R3
    i_grp_clr |=> !o_seen ##1 !o_seen || $past(i_edge))
    else $error("activity bit not cleared by group reset");
  AST_SECOND_EDGE: assert property (@(posedge i_clk) disable iff (!i_rst_n) // see R4
    !o_seen && first_q && i_edge && !i_grp_clr |=> o_seen)
    else $error("second line clock edge did not set activity bit");
  AST_FIRST_EDGE_WAITS: assert property (@(posedge i_clk) disable iff (!i_rst_n) // see R4
    !o_seen && !first_q && i_edge |=> !o_seen)
    else $error("first line clock edge set activity bit");
  AST_NO_EDGE_HOLD: assert property (@(posedge i_clk) disable iff (!i_rst_n) // see R6
    !o_seen && !i_edge |=> !o_seen)
    else $error("activity bit set without an edge");
endmodule
`default_nettype wire

// file: dv/gcca_host_mem_model.sv
// host-side shared memory model, one word per channel group
`timescale 1ns/100ps
`default_nettype none
module gcca_host_mem_model
  import gcca_pkg::*;
(
  input wire logic i_clk,
  input wire gcca_mem_req_s i_req,
  input wire logic i_we,
  output logic [31:0] o_rdata
);
  // ********************
  // storage
  // ********************
  // descriptor blocks sit on 2 kB boundaries, so the group number alone picks one
  logic [31:0] mem_q [8];
  // read data valid in the request cycle
  assign o_rdata = mem_q[i_req.grp];
  initial begin
    for (int g = 0; g < 8; g++) begin
      mem_q[g] = 32'hC0DE_0000 + 32'(g);
    end
  end
  // a write flips the word so a lost or extra write shows
  always @(posedge i_clk) begin
    if (i_we) begin
      mem_q[i_req.grp] <= ~mem_q[i_req.grp];
    end
  end
endmodule
`default_nettype wire

// file: dv/gcca_top_tb.sv
// self-checking bench for the global configuration and clock activity block
`timescale 1ns/100ps
`default_nettype none
module gcca_top_tb;
  import gcca_pkg::*;
  typedef struct packed {
    logic [2:0] grp;
    logic [31:0] wd;
    logic [31:0] exp;
    logic oe;
  } gcca_row_s;
  logic clk, rst_n, chip_rst, cfg_wr, cfg_rd, rel, ram_we, cfg_rv, mem_rv, ok, ck_o, ck_oe, run6;
  logic [7:0] grp_rst, tx_lc, rx_lc;
  logic [2:0] cfg_grp;
  logic [31:0] cfg_wd, cfg_rdat, ram_rdat, mem_rdat, got;
  gcca_mem_req_s req;
  int n_mismatch = 0;
  int tests_run = 0;
  gcca_row_s rows [3] = '{
    '{3'h0, 32'h0000_0800, 32'h0000_0800, 1'b1},
    '{3'h3, 32'h0000_7000, 32'h0000_0800, 1'b1},
    '{3'h0, 32'hFFFF_F0FC, 32'h0000_70FC, 1'b0}};

  gcca_top #(.NGRP(8), .ABSENT_CYCLES(8)) dut_u (.i_clk(clk), .i_rst_n(rst_n),
    .i_soft_chip_rst(chip_rst), .i_soft_grp_rst(grp_rst), .i_tx_line_clock(tx_lc),
    .i_rx_line_clock(rx_lc), .i_cfg_wr(cfg_wr), .i_cfg_grp(cfg_grp), .i_cfg_wdata(cfg_wd),
    .i_cfg_rd(cfg_rd), .o_cfg_rdata(cfg_rdat), .o_cfg_rvalid(cfg_rv), .i_mem_req(req),
    .i_ram_rdata(ram_rdat), .o_ram_we(ram_we), .o_mem_rdata(mem_rdat), .o_mem_rvalid(mem_rv),
    .i_ebus_release(rel), .o_ebus_req_ok(ok), .o_ebus_clock_o(ck_o), .o_ebus_clock_oe(ck_oe));
  gcca_host_mem_model host_u (.i_clk(clk), .i_req(req), .i_we(ram_we), .o_rdata(ram_rdat));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // line clock of port 6 runs only while the bench asks for it
  always @(posedge clk) begin
    if (run6) begin
      tx_lc[6] <= ~tx_lc[6];
    end
  end

  // ********************
  // tasks
  // ********************
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_of_test();
    $display("mismatches %0d checks %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic cfg_write(input logic [2:0] g, input logic [31:0] d);
    @(posedge clk);
    cfg_wr <= 1'b1;
    cfg_grp <= g;
    cfg_wd <= d;
    @(posedge clk);
    cfg_wr <= 1'b0;
    @(posedge clk) #1;
  endtask
  task automatic cfg_read(output logic [31:0] d);
    @(posedge clk);
    cfg_rd <= 1'b1;
    @(posedge clk);
    cfg_rd <= 1'b0;
    #1;
    for (int i = 0; i < 3 && cfg_rv !== 1'b1; i++) @(posedge clk) #1;
    chk("read valid", 32'h1, 32'(cfg_rv));
    d = cfg_rdat;
  endtask
  task automatic lc_pulse(input logic is_tx, input int p, input int n);
    repeat (n) begin
      @(posedge clk);
      if (is_tx) tx_lc[p] <= 1'b1;
      else rx_lc[p] <= 1'b1;
      repeat (2) @(posedge clk);
      tx_lc[p] <= 1'b0;
      rx_lc[p] <= 1'b0;
      repeat (2) @(posedge clk);
    end
    repeat (4) @(posedge clk);
  endtask
  task automatic mem(input logic r, input logic w, input logic exp_we, input logic [31:0] exp_d);
    @(posedge clk);
    req <= '{rd: r, wr: w, grp: 3'h6};
    @(negedge clk);
    chk("ram write enable", 32'(exp_we), 32'(ram_we));
    @(posedge clk);
    req <= '0;
    #1;
    for (int i = 0; r && i < 3 && mem_rv !== 1'b1; i++) @(posedge clk) #1;
    if (r) chk("memory valid", 32'h1, 32'(mem_rv));
    if (r) chk("memory data", exp_d, mem_rdat);
  endtask
  task automatic gap_chk(input logic [2:0] g);
    int lows;
    cfg_write(3'h0, {17'h0, g, 12'h000});
    @(posedge clk);
    rel <= 1'b1;
    @(posedge clk);
    rel <= 1'b0;
    #1;
    lows = 0;
    while (ok === 1'b0 && lows < 20) begin
      lows++;
      @(posedge clk) #1;
    end
    chk("request gap", 32'(g) + 32'h4, 32'(lows));
  endtask

  // ********************
  // sequence
  // ********************
  initial begin
    #100000;
    n_mismatch++;
    end_of_test();
  end
  initial begin
    {rst_n, chip_rst, cfg_wr, cfg_rd, rel, run6} = '0;
    {grp_rst, tx_lc, rx_lc, cfg_grp, cfg_wd} = '0;
    req = '0;
    repeat (6) @(posedge clk);
    #1;
    chk("reset gap ok", 32'h1, 32'(ok));
    chk("reset clock enable", 32'h0, 32'(ck_oe));
    @(posedge clk);
    rst_n <= 1'b1;
    foreach (rows[i]) begin
      cfg_write(rows[i].grp, rows[i].wd);
      chk("clock enable", 32'(rows[i].oe), 32'(ck_oe));
      if (rows[i].oe) chk("clock out", 32'h0, 32'(ck_o));
      cfg_read(got);
      chk("config word", rows[i].exp, got);
    end
    for (int g = 0; g < 8; g++) begin
      cfg_write(3'(g), 32'h0);
    end
    lc_pulse(1'b1, 5, 1);
    cfg_read(got);
    chk("one edge", 32'h0, got);
    // the read restarts the edge pair, so two more edges are needed
    lc_pulse(1'b1, 5, 2);
    cfg_read(got);
    chk("two edges", 32'h2000_0000, got);
    cfg_read(got);
    chk("cleared by read", 32'h0, got);
    lc_pulse(1'b0, 2, 2);
    cfg_read(got);
    chk("rx group 2", 32'h0004_0000, got);
    lc_pulse(1'b1, 3, 2);
    grp_rst <= 8'h08;
    @(posedge clk);
    grp_rst <= '0;
    cfg_read(got);
    chk("group reset", 32'h0, got);
    cfg_write(3'h0, 32'h0000_0001);
    lc_pulse(1'b0, 0, 2);
    cfg_read(got);
    chk("shared port", 32'h0003_0001, got);
    cfg_write(3'h0, 32'h0);
    mem(1'b1, 1'b0, 1'b0, 32'hDEAD_ACCE);
    mem(1'b0, 1'b1, 1'b0, 32'h0);
    run6 <= 1'b1;
    repeat (6) @(posedge clk);
    mem(1'b0, 1'b1, 1'b1, 32'h0);
    mem(1'b1, 1'b0, 1'b0, ~32'hC0DE_0006);
    run6 <= 1'b0;
    repeat (20) @(posedge clk);
    mem(1'b1, 1'b0, 1'b0, 32'hDEAD_ACCE);
    cfg_write(3'h0, 32'h0000_0800);
    lc_pulse(1'b1, 7, 2);
    chip_rst <= 1'b1;
    @(posedge clk);
    chip_rst <= 1'b0;
    cfg_read(got);
    chk("chip reset word", 32'h0, got);
    chk("chip reset enable", 32'h0, 32'(ck_oe));
    lc_pulse(1'b1, 4, 2);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    cfg_read(got);
    chk("bus reset word", 32'h0, got);
    gap_chk(3'h0);
    gap_chk(3'h7);
    end_of_test();
  end
endmodule
`default_nettype wire
